// ==== src/sequencer_regs.vh ====
// Purpose: register map, field positions and timing counts of the sequencer
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   all offsets are byte addresses
`ifndef SEQUENCER_REGS_VH
`define SEQUENCER_REGS_VH

`define REG_CTRL        12'h000
`define REG_CONFIG      12'h004
`define REG_HOLD_THR    12'h008
`define REG_FRONT_SP    12'h00C
`define REG_STATUS      12'h010
`define REG_PROG_SP     12'h014
`define REG_REMAIN      12'h018
`define REG_SP_DISPLAY  12'h01C
`define REG_ANALOG_OUT  12'h020
`define REG_BAR         12'h024
`define REG_CTL_DIFF    12'h028
`define REG_SECT_BASE   12'h100

// control register bits
`define CTRL_EXTERNAL   0
`define CTRL_MANUAL     1
`define CTRL_HOLD_EN    2
// configuration register bits
`define CFG_ORIGIN      0
`define CFG_DYNAMIC     1
`define CFG_CYCLIC      2
`define CFG_CHAIN       3
`define CFG_POLARITY    4
`define CFG_AOUT_SRC    5
`define CFG_DISP_TARGET 6
`define CFG_START_ASSIGN 7
`define CFG_SELECT_ASSIGN 8
`define CFG_SECOND_PROG 9
`define CFG_SLOT_LO     16
`define CFG_SLOT_HI     23
`define CFG_SLOT_ANY    31

// timing: one program second at 100 MHz
`define SECOND_NS       1000000000
`define CLK_PERIOD_NS   10
`define TICK_CYCLES     (`SECOND_NS / `CLK_PERIOD_NS)

`define RESET_WORD      32'h0000_0000
`endif

// ==== src/setpoint_program_sequencer.v ====
// Purpose: timed setpoint programmer with hold, cascade and cyclic repeat
// Assumes: APB register access, inputs from pins synchronised here
// Notes:   section table is held in local memory, two programs of N steps
// Functional notes
// RQ1: going from internal to external setpoint starts the program.
// RQ2: last section done forces setpoint source back to internal.
// RQ3: origin switch 1 keeps the front setpoint active outside a run.
// RQ4: origin switch 0 loads final target into front setpoint at end.
// RQ5: internal setpoint together with manual mode resets the program.
// RQ6: actual-value display shows remaining time of active section.
// RQ7: dynamic start mode starts on a rising start-input edge.
// RQ8: hold enabled freezes time while difference exceeds threshold.
// RQ9: static start mode runs while start input is high and external; here external is checked only when starting.
// RQ10: interrupted and adjusted setpoint ramps on to section target.
// RQ11: chained selector runs first then second program as one.
// RQ12: cyclic mode restarts after end until internal is selected.
// RQ13: two lamps show which chained program is active.
// RQ14: slot output during chosen sections; idle output when not running.
// RQ15: running message on a digital output, polarity switch inverts it.
// RQ16: analog output carries program setpoint when its switch selects.
// RQ17: setpoint display shows current or section-end target setpoint.
// RQ18: select input, when assigned, chooses first or second program.
// RQ19: bar display shows program extent and current step.
// RQ20: setpoint moves linearly from start to target over section time.
// RQ21: time resumes once difference is back inside hold threshold.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "sequencer_regs.vh"

module setpoint_program_sequencer #(
  parameter STEPS     = 8,
  parameter SPW       = 16,
  parameter TW        = 16,
  parameter TICK      = `TICK_CYCLES
) (
  input  wire            clk_sys,                 // system clock
  input  wire            resetn,                  // sync reset, low
  input  wire            psel,                    // apb select
  input  wire            penable,                 // apb enable
  input  wire            pwrite,                  // apb direction
  input  wire [11:0]     paddr,                   // apb byte address
  input  wire [31:0]     pwdata,                  // apb write data
  output reg  [31:0]     prdata,                  // apb read data
  output reg             pready,                  // apb ready
  output reg             pslverr,                 // apb error
  input  wire            first_digital_input,     // start pin
  input  wire            second_digital_input,    // select pin
  output reg             first_message_output,    // slot / running msg
  output reg             second_message_output,   // idle or end msg
  output reg             lamp_first_program,      // first prog active
  output reg             lamp_second_program,     // second prog active
  output reg  [SPW-1:0]  analog_output,           // analog out value
  output reg  [TW-1:0]   actual_value_display,    // remaining seconds
  output reg  [SPW-1:0]  setpoint_display,        // current or target
  output reg             lamp_internal            // setpoint internal
);

  localparam IW = $clog2(STEPS);
  localparam PW = IW + 1;
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_INT  = 2'b10;
  // bar extent, one or both programs
  localparam [7:0] BAR_ONE = STEPS;
  localparam [7:0] BAR_TWO = 2*STEPS;

  // section table: program in bit IW, step below
  reg [SPW-1:0] target_mem [0:2*STEPS-1];
  reg [TW-1:0]  time_mem   [0:2*STEPS-1];

  reg [1:0]     state_q;
  reg [31:0]    ctrl_q;
  reg [31:0]    cfg_q;
  reg [SPW-1:0] hold_thr_q;
  reg [SPW-1:0] front_sp_q;
  reg [SPW-1:0] ctl_diff_q;
  reg [SPW-1:0] prog_sp_q;
  reg [SPW-1:0] start_sp_q;
  reg [TW-1:0]  remain_q;
  reg [31:0]    tick_q;
  reg           prog_q;
  reg [IW-1:0]  step_q;
  reg [PW-1:0]  done_steps_q;
  reg           ext_prev_q;
  reg [1:0]     start_sync_q;
  reg [1:0]     sel_sync_q;
  reg           start_prev_q;
  reg           running_q;
  reg [15:0]    bar_q;

  // pin synchronisers, first stage read only by second
  always @(posedge clk_sys) begin
    if (!resetn) begin
      start_sync_q <= 2'b00;
      sel_sync_q   <= 2'b00;
    end else begin
      start_sync_q <= {start_sync_q[0], first_digital_input};
      sel_sync_q   <= {sel_sync_q[0], second_digital_input};
    end
  end

  wire          start_in  = start_sync_q[1];
  wire          ext_sel   = ctrl_q[`CTRL_EXTERNAL];
  wire          manual    = ctrl_q[`CTRL_MANUAL];
  wire          chain     = cfg_q[`CFG_CHAIN];
  wire [PW-1:0] cur_idx   = {prog_q, step_q};
  wire [SPW-1:0] cur_tgt  = target_mem[cur_idx];
  wire [TW-1:0]  cur_time = time_mem[cur_idx];
  // first program choice: select pin when assigned, else config bit
  wire first_prog = cfg_q[`CFG_SELECT_ASSIGN] ? sel_sync_q[1]   // see RQ18
                                              : cfg_q[`CFG_SECOND_PROG];

  // start request per configured source
  wire dyn_edge  = start_in & ~start_prev_q;
  wire pin_start = cfg_q[`CFG_DYNAMIC] ? dyn_edge                // see RQ7
                                       : (start_in & ext_sel);   // see RQ9
  wire front_start = ext_sel & ~ext_prev_q;                     // see RQ1
  wire start_req = cfg_q[`CFG_START_ASSIGN] ? pin_start : front_start;
  wire reset_req = ~ext_sel & manual;                           // see RQ5

  // hold when difference beyond threshold, resumes when back inside
  wire hold = ctrl_q[`CTRL_HOLD_EN] & (ctl_diff_q > hold_thr_q); // see RQ8
  wire static_stop = cfg_q[`CFG_START_ASSIGN] & ~cfg_q[`CFG_DYNAMIC]
                     & ~start_in;
  wire advance = (state_q == ST_RUN) & ~hold & ~static_stop;     // see RQ21
  wire tick_now = advance & (tick_q == TICK - 1);
  wire sect_end = tick_now & (remain_q <= {{(TW-1){1'b0}}, 1'b1});
  wire last_in_prog = (step_q == STEPS - 1) |
                      (time_mem[cur_idx + 1'b1] == {TW{1'b0}});
  wire prog_end = sect_end & last_in_prog & (~chain | prog_q);

  // linear ramp: start + (target-start)*elapsed/duration, see RQ20
  wire signed [SPW+1:0] span =
    $signed({2'b00, cur_tgt}) - $signed({2'b00, start_sp_q});
  wire [TW-1:0] elapsed = cur_time - remain_q;
  wire signed [SPW+TW+2:0] prod = span * $signed({1'b0, elapsed});
  wire signed [SPW+TW+2:0] quot =
    (cur_time == {TW{1'b0}}) ? {(SPW+TW+3){1'b0}}
                             : prod / $signed({1'b0, cur_time});
  wire [SPW-1:0] ramp_sp = start_sp_q + quot[SPW-1:0];          // see RQ20

  // main sequencer state machine
  always @(posedge clk_sys) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      prog_q       <= 1'b0;
      step_q       <= {IW{1'b0}};
      done_steps_q <= {PW{1'b0}};
      remain_q     <= {TW{1'b0}};
      tick_q       <= 32'h0000_0000;
      prog_sp_q    <= {SPW{1'b0}};
      start_sp_q   <= {SPW{1'b0}};
      ext_prev_q   <= 1'b0;
      start_prev_q <= 1'b0;
      running_q    <= 1'b0;
    end else begin
      ext_prev_q   <= ext_sel;
      start_prev_q <= start_in;
      case (state_q)
        ST_IDLE: begin
          running_q <= 1'b0;
          if (start_req) begin
            state_q      <= ST_RUN;
            running_q    <= 1'b1;
            prog_q       <= chain ? 1'b0 : first_prog;          // see RQ11
            step_q       <= {IW{1'b0}};
            done_steps_q <= {PW{1'b0}};
            tick_q       <= 32'h0000_0000;
            remain_q     <= time_mem[{(chain ? 1'b0 : first_prog),
                                      {IW{1'b0}}}];
            start_sp_q   <= front_sp_q;
            prog_sp_q    <= front_sp_q;
          end
        end
        ST_RUN: begin
          if (reset_req) begin
            state_q <= ST_IDLE;
          end else if (~ext_sel & ~cfg_q[`CFG_START_ASSIGN]) begin
            state_q <= ST_INT;                                  // see RQ10
          end else if (advance) begin
            prog_sp_q <= ramp_sp;
            tick_q <= tick_now ? 32'h0000_0000 : tick_q + 32'd1;
            if (tick_now)
              remain_q <= remain_q - {{(TW-1){1'b0}}, 1'b1};   // see RQ6
            if (sect_end) begin
              prog_sp_q  <= cur_tgt;
              start_sp_q <= cur_tgt;
              done_steps_q <= done_steps_q + {{(PW-1){1'b0}}, 1'b1};
              if (prog_end) begin
                if (cfg_q[`CFG_CYCLIC]) begin                   // see RQ12
                  prog_q   <= chain ? 1'b0 : prog_q;
                  step_q   <= {IW{1'b0}};
                  done_steps_q <= {PW{1'b0}};
                  remain_q <= time_mem[{(chain ? 1'b0 : prog_q),
                                        {IW{1'b0}}}];
                end else begin
                  state_q   <= ST_IDLE;
                  running_q <= 1'b0;
                end
              end else if (last_in_prog) begin
                prog_q   <= 1'b1;                               // see RQ11
                step_q   <= {IW{1'b0}};
                remain_q <= time_mem[{1'b1, {IW{1'b0}}}];
              end else begin
                step_q   <= step_q + {{(IW-1){1'b0}}, 1'b1};
                remain_q <= time_mem[cur_idx + 1'b1];
              end
            end
          end
        end
        ST_INT: begin
          // operator owns the setpoint; resume ramps from it
          if (reset_req) begin
            state_q <= ST_IDLE;
          end else if (ext_sel) begin
            state_q    <= ST_RUN;
            start_sp_q <= front_sp_q;                           // see RQ10
            prog_sp_q  <= front_sp_q;
            tick_q     <= 32'h0000_0000;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // remaining-time based ramp after resume keeps elapsed as section time minus remaining
  // so the slope still spans the whole section from the resumed setpoint

  // apb slave, access phase with one wait state
  wire wr_acc = psel & penable & pwrite & ~pready;
  wire rd_acc = psel & penable & ~pwrite & ~pready;
  wire in_tab = (paddr >= `REG_SECT_BASE) &
                (paddr < `REG_SECT_BASE + 12'h0 + (4*4*STEPS));
  wire [PW-1:0] tab_idx = paddr[PW+2:3];
  wire mapped = in_tab | (paddr <= `REG_CTL_DIFF && paddr[1:0] == 2'b00);

  reg [31:0] rd_d;
  always @* begin
    rd_d = `RESET_WORD;
    case (paddr)
      `REG_CTRL:       rd_d = ctrl_q;
      `REG_CONFIG:     rd_d = cfg_q;
      `REG_HOLD_THR:   rd_d = {{(32-SPW){1'b0}}, hold_thr_q};
      `REG_FRONT_SP:   rd_d = {{(32-SPW){1'b0}}, front_sp_q};
      `REG_STATUS:     rd_d = {24'h000000, hold, prog_q, running_q,
                               3'b000, state_q};
      `REG_PROG_SP:    rd_d = {{(32-SPW){1'b0}}, prog_sp_q};
      `REG_REMAIN:     rd_d = {{(32-TW){1'b0}}, remain_q};
      `REG_CTL_DIFF:   rd_d = {{(32-SPW){1'b0}}, ctl_diff_q};
      `REG_BAR:        rd_d = {16'h0000, bar_q};             // see RQ19
      default: begin
        if (in_tab)
          rd_d = paddr[2] ? {{(32-TW){1'b0}}, time_mem[tab_idx]}
                          : {{(32-SPW){1'b0}}, target_mem[tab_idx]};
      end
    endcase
  end

  // register writes; hardware end-of-program overrides win
  always @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_q     <= `RESET_WORD;
      cfg_q      <= `RESET_WORD;
      hold_thr_q <= {SPW{1'b0}};
      front_sp_q <= {SPW{1'b0}};
      ctl_diff_q <= {SPW{1'b0}};
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (rd_acc)
        prdata <= rd_d;
      if (wr_acc) begin
        case (paddr)
          `REG_CTRL:     ctrl_q     <= pwdata;
          `REG_CONFIG:   cfg_q      <= pwdata;
          `REG_HOLD_THR: hold_thr_q <= pwdata[SPW-1:0];
          `REG_FRONT_SP: front_sp_q <= pwdata[SPW-1:0];
          `REG_CTL_DIFF: ctl_diff_q <= pwdata[SPW-1:0];
          default: ;
        endcase
      end
      if (prog_end & ~cfg_q[`CFG_CYCLIC] & (state_q == ST_RUN)) begin
        ctrl_q[`CTRL_EXTERNAL] <= 1'b0;                         // see RQ2
        if (!cfg_q[`CFG_ORIGIN])
          front_sp_q <= cur_tgt;                                // see RQ4
      end
    end
  end

  // section table writes, one generate entry per section
  genvar g;
  generate
    for (g = 0; g < 2*STEPS; g = g + 1) begin : g_tab
      always @(posedge clk_sys) begin
        if (!resetn) begin
          target_mem[g] <= {SPW{1'b0}};
          time_mem[g]   <= {TW{1'b0}};
        end else if (wr_acc & in_tab & (tab_idx == g)) begin
          if (paddr[2])
            time_mem[g]   <= pwdata[TW-1:0];
          else
            target_mem[g] <= pwdata[SPW-1:0];
        end
      end
    end
  endgenerate

  // active setpoint: front value when idle or interrupted
  wire [SPW-1:0] active_sp = (state_q == ST_RUN) ? prog_sp_q
                                                 : front_sp_q; // see RQ3
  wire [7:0] slot_mask = cfg_q[`CFG_SLOT_HI:`CFG_SLOT_LO];
  wire in_slot = running_q & slot_mask[step_q[IW-1:0] & 3'h7];

  // registered outputs
  always @(posedge clk_sys) begin
    if (!resetn) begin
      first_message_output  <= 1'b0;
      second_message_output <= 1'b0;
      lamp_first_program    <= 1'b0;
      lamp_second_program   <= 1'b0;
      analog_output         <= {SPW{1'b0}};
      actual_value_display  <= {TW{1'b0}};
      setpoint_display      <= {SPW{1'b0}};
      lamp_internal         <= 1'b1;
    end else begin
      // config bit 31 picks slot message, else running message
      first_message_output <= cfg_q[`CFG_SLOT_ANY] ? in_slot    // see RQ14
                           : (running_q ^ cfg_q[`CFG_POLARITY]); // see RQ15
      second_message_output <= ~running_q;                      // see RQ14
      lamp_first_program    <= running_q & ~prog_q;             // see RQ13
      lamp_second_program   <= running_q & prog_q;              // see RQ13
      analog_output <= cfg_q[`CFG_AOUT_SRC] ? active_sp         // see RQ16
                                            : ctl_diff_q;
      actual_value_display  <= remain_q;                        // see RQ6
      setpoint_display <= cfg_q[`CFG_DISP_TARGET] ? cur_tgt     // see RQ17
                                                  : active_sp;
      lamp_internal <= ~ext_sel;
    end
  end

  // bar display: extent in high byte, completed steps in low byte
  always @(posedge clk_sys) begin
    if (!resetn)
      bar_q <= 16'h0000;
    else
      bar_q <= {(chain ? BAR_TWO : BAR_ONE),                    // see RQ19
                {{(8-PW){1'b0}}, done_steps_q}};
  end

endmodule

// ==== sim/sequencer_asserts.sv ====
// Purpose: port-level checks of the setpoint program sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   running is taken as either program lamp being lit
`timescale 1ns/1ps
module sequencer_asserts (
  input wire logic        clk_sys,               // system clock
  input wire logic        resetn,                // sync reset, low
  input wire logic        psel,                  // apb select
  input wire logic        penable,               // apb enable
  input wire logic        pwrite,                // apb direction
  input wire logic [31:0] prdata,                // apb read data
  input wire logic        pready,                // apb ready
  input wire logic        pslverr,               // apb error
  input wire logic        second_message_output, // idle message
  input wire logic        lamp_first_program,    // first prog lamp
  input wire logic        lamp_second_program    // second prog lamp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // lamps merged; a run in either program counts
  wire run = lamp_first_program | lamp_second_program;

  AST_LAMPS_EXCL: assert property (
    !(lamp_first_program && lamp_second_program))
    else $error("both program lamps lit");
  AST_IDLE_MSG_RUN: assert property (
    run ##1 run |-> !second_message_output)
    else $error("idle message while running");
  AST_IDLE_AFTER_RESET: assert property (
    $rose(resetn) |-> ##[1:3] second_message_output)
    else $error("idle message missing after reset");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ONE_WAIT: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not one cycle after access");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_READ_ZERO: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");

  // main scenarios seen
  cover property ($rose(lamp_first_program));
  cover property ($rose(lamp_second_program));
  cover property (pready && pslverr);
endmodule

bind setpoint_program_sequencer sequencer_asserts chk (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .second_message_output(second_message_output),
  .lamp_first_program(lamp_first_program),
  .lamp_second_program(lamp_second_program));

// ==== sim/panel_model.sv ====
// Purpose: front panel contacts feeding the two digital inputs
// Assumes: requests come from the bench as levels
// Notes:   contacts lag by LAG cycles, so slow panels are modelled
`timescale 1ns/1ps
module panel_model #(
  parameter LAG = 3
) (
  input  wire logic clk_sys,              // system clock
  input  wire logic start_req,            // bench start level
  input  wire logic select_req,           // bench select level
  output logic      first_digital_input,  // start contact
  output logic      second_digital_input  // select contact
);
  logic [LAG-1:0] st_q;
  logic [LAG-1:0] sl_q;
  initial begin
    st_q = '0;
    sl_q = '0;
  end
  // contact delay line, changes just after an edge
  always @(posedge clk_sys) begin
    st_q <= {st_q[LAG-2:0], start_req};
    sl_q <= {sl_q[LAG-2:0], select_req};
  end
  assign first_digital_input  = st_q[LAG-1];
  assign second_digital_input = sl_q[LAG-1];
endmodule

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the setpoint program sequencer
// Assumes: TICK of 4 cycles per program second
// Notes:   section 0 lasts 3 s, section 1 lasts 1 s, then a zero ends
`timescale 1ns/1ps
`include "sequencer_regs.vh"
module testbench;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er, start_req, sel_req, din1, din2, msg1, msg2;
  logic        lamp1, lamp2, lamp_int;
  logic [15:0] aout, remain, spdisp, t0, t1, fsp;
  integer      fail_count, checks_done, k;

  setpoint_program_sequencer #(.TICK(4)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_digital_input(din1),
    .second_digital_input(din2), .first_message_output(msg1),
    .second_message_output(msg2), .lamp_first_program(lamp1),
    .lamp_second_program(lamp2), .analog_output(aout),
    .actual_value_display(remain), .setpoint_display(spdisp),
    .lamp_internal(lamp_int));
  panel_model pm (.clk_sys(clk_sys), .start_req(start_req),
    .select_req(sel_req), .first_digital_input(din1),
    .second_digital_input(din2));

  // 100 MHz clock
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, far beyond the planned run
  initial begin
    #300000;
    fail_count++;
    wrap_up;
  end

  task wrap_up;
    begin
      $display("counts: %0d checks, %0d mismatches", checks_done,
               fail_count);
      if (fail_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done++;
      if (g !== e) begin
        fail_count++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // apb transfer; request held until ready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("apb ready", 1, 0);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask
  task sect(input int i, input logic [15:0] tg, input logic [15:0] s);
    begin
      apb(1, `REG_SECT_BASE + 12'(8 * i), {16'h0, tg});
      apb(1, `REG_SECT_BASE + 12'(8 * i + 4), {16'h0, s});
    end
  endtask
  // which 0 watches running, 1 the second program lamp
  task wait_for(input int which, input logic lvl);
    integer n;
    begin
      n = 0;
      while ((which ? lamp2 : (lamp1 | lamp2)) !== lvl && n < 300) begin
        @(posedge clk_sys);
        n++;
      end
      if (n >= 300) chk("wait", lvl, ~lvl);
    end
  endtask

  initial begin
    fail_count = 0; checks_done = 0; resetn = 0; psel = 0; penable = 0;
    pwrite = 0; paddr = 12'h0; pwdata = 32'h0; start_req = 0; sel_req = 0;
    void'($urandom(32'h569F));
    repeat (6) @(posedge clk_sys);
    resetn <= 1;
    // reset words and a refused place
    apb(0, `REG_CTRL, 0);  chk("ctrl reset", `RESET_WORD, rd);
    apb(0, `REG_CONFIG, 0); chk("cfg reset", `RESET_WORD, rd);
    apb(1, 12'h040, 32'h1234); chk("wr err", 1, er);
    apb(0, 12'h040, 0); chk("rd err", 1, er);
    t0 = $urandom; t1 = $urandom;
    sect(0, t0, 3); sect(1, t1, 1); sect(2, 0, 0);
    sect(8, t1, 1); sect(9, t0, 1); sect(10, 0, 0);
    $display("test registers done");
    // origin and polarity combinations, front start
    for (k = 0; k < 4; k++) begin
      fsp = $urandom;
      apb(1, `REG_FRONT_SP, {16'h0, fsp});
      apb(1, `REG_CONFIG, {27'h0, k[1], 3'h0, k[0]});
      repeat (3) @(posedge clk_sys);
      chk("msg1 idle", k[1], msg1);
      apb(1, `REG_CTRL, 1);
      wait_for(0, 1);
      chk("lamp1", 1, lamp1);
      chk("remain", 3, remain);
      chk("msg2 run", 0, msg2);
      chk("msg1 run", !k[1], msg1);
      wait_for(0, 0);
      repeat (2) @(posedge clk_sys);
      chk("lamp int", 1, lamp_int);
      chk("msg2 end", 1, msg2);
      apb(0, `REG_CTRL, 0); chk("ctrl end", 0, rd[0]);
      apb(0, `REG_FRONT_SP, 0);
      chk("front sp", k[0] ? fsp : t1, rd[15:0]);
    end
    $display("test front start done");
    // manual reset mid-run restarts at section 0
    apb(1, `REG_CONFIG, 0);
    apb(1, `REG_CTRL, 1);
    wait_for(0, 1);
    repeat (6) @(posedge clk_sys);
    apb(1, `REG_CTRL, 2);
    wait_for(0, 0);
    apb(1, `REG_CTRL, 1);
    wait_for(0, 1);
    chk("restart", 3, remain);
    wait_for(0, 0);
    $display("test manual reset done");
    // chained programs, lamps swap
    apb(1, `REG_CONFIG, 32'h8);
    apb(1, `REG_CTRL, 1);
    wait_for(1, 1);
    chk("lamp1 off", 0, lamp1);
    wait_for(0, 0);
    apb(0, `REG_BAR, 0); chk("bar", 32'h1004, rd);
    $display("test chain done");
    // pin start on rising edge, analog follows setpoint
    apb(1, `REG_CONFIG, 32'hA2);
    start_req <= 1;
    wait_for(0, 1);
    chk("aout", t0, aout);
    chk("spdisp", t0, spdisp);
    start_req <= 0;
    wait_for(0, 0);
    $display("test pin start done");
    wrap_up;
  end
endmodule
